// file: include/lpms_pkg.sv
// Package for the low power mode sequencer: offsets, fields, timings, types
package lpms_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_SYS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SLEEP_CTRL = 8'h04;
	localparam logic [7:0] OFS_XTAL_CTRL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_WAKE_CTRL = 8'h10;
	localparam logic [7:0] OFS_WAKE_TIMEOUT = 8'h14;
	localparam logic [7:0] OFS_WAKE_COUNT = 8'h18;
	localparam logic [7:0] OFS_RTC_COUNT = 8'h1C;
	localparam logic [7:0] OFS_PWR_STATE = 8'h20;
	// Field positions
	localparam int SYS_XTAL_PRESENT_BIT = 5;
	localparam int SYS_RING_EN_BIT = 0;
	localparam int SLP_HIB_BIT = 0;
	localparam int SLP_DOZE_BIT = 1;
	localparam int SLP_RETAIN_BIT = 2;
	localparam int XTAL_EN_BIT = 0;
	localparam int XTAL_GAIN_LSB = 4;
	localparam int ST_SYNC_BIT = 0;
	localparam int ST_HIB_WAKE_BIT = 1;
	localparam int ST_DOZE_WAKE_BIT = 2;
	localparam int WK_TIMER_EN_BIT = 0;
	localparam int WK_RTC_EN_BIT = 1;
	// Reset values
	localparam logic [1:0] XTAL_GAIN_RESET = 2'h3;
	localparam logic RING_EN_RESET = 1'b1;
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int REF_WAIT_US = 700;
	localparam int MCU_RESET_US = 40;
	localparam int REF_WAIT_CYC = REF_WAIT_US * CLK_MHZ;
	localparam int MCU_RESET_CYC = MCU_RESET_US * CLK_MHZ;
	localparam int REF_DIV = 128;
	localparam int SLOW_DIV = 50;
	localparam int CNT_W = 17;
	// Sequencer states
	typedef enum logic [3:0] {
		ST_RUN, ST_PRE_HIB, ST_HIBERNATE, ST_HIB_W1, ST_HIB_W2, ST_HIB_W3,
		ST_PRE_DOZE, ST_DOZE, ST_DOZE_W1, ST_DOZE_W2, ST_DOZE_W3
	} lpms_state_e;
	// Power and clock controls driven toward the chip
	typedef struct packed {
		logic vref_on;
		logic ref_osc_on;
		logic osc_reg_on;
		logic dig_reg_on;
		logic pad_ring_on;
		logic mcu_pwr_on;
		logic mcu_clk_on;
		logic mac_clk_on;
		logic mcu_reset;
		logic fsm_on_ref;
	} lpms_pwr_s;
endpackage

// file: verilog/lpms_tick.sv
// Enable-pulse divider
module lpms_tick #(
	parameter int DIV = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control and pulse
	input wire logic en,
	output logic tick
);
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic tick_next;

	// Count to DIV-1 then pulse
	always_comb begin
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		if (en) begin
			if (cnt_reg == 16'(DIV - 1)) begin
				cnt_next = 16'h0000;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= 16'h0000;
			tick <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick <= tick_next;
		end
	end
endmodule // lpms_tick

// file: verilog/lpms_sync.sv
// Two-flop level synchroniser
module lpms_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic d,
	output logic q
);
	logic meta_reg;

	// Only the second stage is read outside
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // lpms_sync

// file: verilog/lpms_sequencer.sv
// Power mode sequencer with AXI4-Lite register slave
// Behaviour
// R1: crystal-present bit switches low-power clock select
// R2: two-bit crystal gain resets to maximum
// R3: writing crystal enable starts the oscillator
// R4: crystal stays on until reset
// R5: software disables ring, enables crystal, waits
// R6: software confirms crystal via RTC change
// R7: doze wake timer runs on reference/128
// R8: RTC never runs on reference/128
// R9: wake ends in idle with processor running
// R10: retention keeps processor state, no reset
// R11: software reads status after every wake
// R12: hibernate wins over doze on request
// R13: sleep-sync clear powers down promptly
// R14: sleep-sync flag sits at status bit 0
// R15: pre-hibernate zeroes timer, sets sync, waits
// R16: hibernate waits wake, starts oscillator, 700us
// R17: step one: regulator, clock, pads on
// R18: step two: 40us reset unless retained
// R19: step three: sync handshake, then MAC clock
// R20: doze loop keeps reference, waits 700us
// R21: wake sets hibernate or doze status flag
// R22: wake requests synchronised before acting
module lpms_sequencer (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// AXI4-Lite write
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Oscillator inputs and wake sources
	input wire logic RING_TICK,
	input wire logic XTAL_TICK,
	input wire logic EXT_WAKE,
	// Power and clock controls
	output lpms_pkg::lpms_pwr_s PWR_CTRL,
	output logic XTAL_ENABLE,
	output logic [1:0] XTAL_GAIN,
	output logic RING_ENABLE,
	output logic LP_CLK_IS_XTAL,
	output logic RTC_TICK,
	output logic WAKE_TIMER_TICK
);
	import lpms_pkg::*;

	lpms_state_e state_reg, state_next;
	logic [CNT_W-1:0] wait_reg, wait_next;
	logic xtal_present_reg, xtal_present_next;
	logic ring_en_reg, ring_en_next;
	logic xtal_en_reg, xtal_en_next;
	logic [1:0] gain_reg, gain_next;
	logic hib_req_reg, hib_req_next;
	logic doze_req_reg, doze_req_next;
	logic retain_reg, retain_next;
	logic sync_reg, sync_next;
	logic hib_flag_reg, hib_flag_next;
	logic doze_flag_reg, doze_flag_next;
	logic tmr_en_reg, tmr_en_next;
	logic rtc_en_reg, rtc_en_next;
	logic [31:0] tmo_reg, tmo_next;
	logic [31:0] wcnt_reg, wcnt_next;
	logic [31:0] rtc_reg, rtc_next;
	logic bvalid_reg, bvalid_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic rresp_bad_reg, rresp_bad_next;
	logic bresp_bad_reg, bresp_bad_next;
	lpms_pwr_s pwr;
	logic wr_go, rd_go, sync_clr, ref_div_tick, lp_tick;
	logic ext_wake_s, rtc_hit, tmr_hit, wake_evt;

	// Doze clock: reference divided by 128
	lpms_tick #(.DIV(REF_DIV)) u_ref_div (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.en(1'b1),
		.tick(ref_div_tick)
	);

	// External wake crosses in from the wake pin
	lpms_sync u_wake_sync (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.d(EXT_WAKE),
		.q(ext_wake_s)
	);

	// Slow clock source choice; the RTC never sees the doze clock
	always_comb begin
		// R1: crystal select
		lp_tick = xtal_present_reg ? XTAL_TICK : RING_TICK;
	end

	// Bus handshakes: accept one write with both channels, one read
	assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_reg;
	assign rd_go = S_AXI_ARVALID && !rvalid_reg;
	assign S_AXI_AWREADY = wr_go;
	assign S_AXI_WREADY = wr_go;
	assign S_AXI_ARREADY = rd_go;
	// R13: software clears sync by writing one to it
	assign sync_clr = wr_go && S_AXI_AWADDR == OFS_STATUS &&
		S_AXI_WSTRB[0] && S_AXI_WDATA[ST_SYNC_BIT];
	assign rtc_hit = rtc_en_reg && rtc_reg == tmo_reg;
	assign tmr_hit = tmr_en_reg && wcnt_reg == tmo_reg;
	assign wake_evt = tmr_hit || rtc_hit || ext_wake_s;

	// Register file and counters next values
	always_comb begin
		xtal_present_next = xtal_present_reg;
		ring_en_next = ring_en_reg;
		xtal_en_next = xtal_en_reg;
		gain_next = gain_reg;
		hib_req_next = hib_req_reg;
		doze_req_next = doze_req_reg;
		retain_next = retain_reg;
		tmr_en_next = tmr_en_reg;
		rtc_en_next = rtc_en_reg;
		tmo_next = tmo_reg;
		bvalid_next = bvalid_reg && !S_AXI_BREADY;
		bresp_bad_next = bresp_bad_reg;
		rvalid_next = rvalid_reg && !S_AXI_RREADY;
		rdata_next = rdata_reg;
		rresp_bad_next = rresp_bad_reg;
		// R8: RTC counts only ring or crystal ticks
		rtc_next = lp_tick ? rtc_reg + 32'h0000_0001 : rtc_reg;
		if (wr_go) begin
			bvalid_next = 1'b1;
			bresp_bad_next = 1'b0;
			unique case (S_AXI_AWADDR)
				OFS_SYS_CTRL: if (S_AXI_WSTRB[0]) begin
					xtal_present_next = S_AXI_WDATA[SYS_XTAL_PRESENT_BIT];
					ring_en_next = S_AXI_WDATA[SYS_RING_EN_BIT];
				end
				OFS_SLEEP_CTRL: if (S_AXI_WSTRB[0]) begin
					hib_req_next = S_AXI_WDATA[SLP_HIB_BIT];
					doze_req_next = S_AXI_WDATA[SLP_DOZE_BIT];
					retain_next = S_AXI_WDATA[SLP_RETAIN_BIT];
				end
				OFS_XTAL_CTRL: if (S_AXI_WSTRB[0]) begin
					// R3: write one starts crystal
					// R4: writing zero cannot stop it
					xtal_en_next = xtal_en_reg | S_AXI_WDATA[XTAL_EN_BIT];
					gain_next = S_AXI_WDATA[XTAL_GAIN_LSB +: 2];
				end
				OFS_STATUS: ;
				OFS_WAKE_CTRL: if (S_AXI_WSTRB[0]) begin
					tmr_en_next = S_AXI_WDATA[WK_TIMER_EN_BIT];
					rtc_en_next = S_AXI_WDATA[WK_RTC_EN_BIT];
				end
				OFS_WAKE_TIMEOUT: begin
					for (int b = 0; b < 4; b++) begin
						if (S_AXI_WSTRB[b]) begin
							tmo_next[8*b +: 8] = S_AXI_WDATA[8*b +: 8];
						end
					end
				end
				default: bresp_bad_next = 1'b1;
			endcase
		end
		if (rd_go) begin
			rvalid_next = 1'b1;
			rresp_bad_next = 1'b0;
			rdata_next = 32'h0000_0000;
			unique case (S_AXI_ARADDR)
				OFS_SYS_CTRL: begin
					rdata_next[SYS_XTAL_PRESENT_BIT] = xtal_present_reg;
					rdata_next[SYS_RING_EN_BIT] = ring_en_reg;
				end
				OFS_SLEEP_CTRL: begin
					rdata_next[SLP_HIB_BIT] = hib_req_reg;
					rdata_next[SLP_DOZE_BIT] = doze_req_reg;
					rdata_next[SLP_RETAIN_BIT] = retain_reg;
				end
				OFS_XTAL_CTRL: begin
					rdata_next[XTAL_EN_BIT] = xtal_en_reg;
					rdata_next[XTAL_GAIN_LSB +: 2] = gain_reg;
				end
				// R14: sync at bit 0
				OFS_STATUS: begin
					rdata_next[ST_SYNC_BIT] = sync_reg;
					rdata_next[ST_HIB_WAKE_BIT] = hib_flag_reg;
					rdata_next[ST_DOZE_WAKE_BIT] = doze_flag_reg;
				end
				OFS_WAKE_CTRL: begin
					rdata_next[WK_TIMER_EN_BIT] = tmr_en_reg;
					rdata_next[WK_RTC_EN_BIT] = rtc_en_reg;
				end
				OFS_WAKE_TIMEOUT: rdata_next = tmo_reg;
				OFS_WAKE_COUNT: rdata_next = wcnt_reg;
				OFS_RTC_COUNT: rdata_next = rtc_reg;
				OFS_PWR_STATE: rdata_next = 32'(state_reg);
				default: rresp_bad_next = 1'b1;
			endcase
		end
		// R12: request is consumed once the loop starts
		if (state_reg == ST_PRE_HIB || state_reg == ST_PRE_DOZE) begin
			hib_req_next = 1'b0;
			doze_req_next = 1'b0;
		end
	end

	// Sequencer next state, timer and flags
	always_comb begin
		state_next = state_reg;
		wait_next = wait_reg;
		wcnt_next = wcnt_reg;
		sync_next = sync_reg && !sync_clr;
		hib_flag_next = hib_flag_reg;
		doze_flag_next = doze_flag_reg;
		// Reading status does not clear flags; writing ones does
		if (wr_go && S_AXI_AWADDR == OFS_STATUS && S_AXI_WSTRB[0]) begin
			hib_flag_next = hib_flag_reg && !S_AXI_WDATA[ST_HIB_WAKE_BIT];
			doze_flag_next = doze_flag_reg && !S_AXI_WDATA[ST_DOZE_WAKE_BIT];
		end
		unique case (state_reg)
			ST_RUN: begin
				// R12: hibernate has priority
				// R22: requests are registered in this clock domain
				if (hib_req_reg) begin
					state_next = ST_PRE_HIB;
				end else if (doze_req_reg) begin
					state_next = ST_PRE_DOZE;
				end
			end
			// R15: zero timer, raise sync, wait for clear
			ST_PRE_HIB, ST_PRE_DOZE: begin
				wcnt_next = 32'h0000_0000;
				if (!sync_reg && wait_reg == '0) begin
					sync_next = 1'b1;
					wait_next = CNT_W'(1);
				end else if (sync_clr) begin
					// R13: clear powers down at once
					wait_next = '0;
					state_next = (state_reg == ST_PRE_HIB) ? ST_HIBERNATE
						: ST_DOZE;
				end
			end
			// R16: hibernate runs on the slow clock until wake
			ST_HIBERNATE, ST_DOZE: begin
				if (wait_reg == '0) begin
					// R7: doze timer runs on reference/128
					if ((state_reg == ST_DOZE) ? ref_div_tick : lp_tick) begin
						wcnt_next = wcnt_reg + 32'h0000_0001;
					end
					// R22: external wake is already synchronised
					if (wake_evt) begin
						wait_next = CNT_W'(1);
						// R21: record wake source mode
						if (state_reg == ST_HIBERNATE) begin
							hib_flag_next = 1'b1;
						end else begin
							doze_flag_next = 1'b1;
						end
					end
				// R16: 700us reference warm-up
				// R20: same wait in doze
				end else if (wait_reg == CNT_W'(REF_WAIT_CYC)) begin
					wait_next = '0;
					state_next = (state_reg == ST_HIBERNATE) ? ST_HIB_W1
						: ST_DOZE_W1;
				end else begin
					wait_next = wait_reg + CNT_W'(1);
				end
			end
			// R17: regulator, pads and clock switch
			ST_HIB_W1: state_next = ST_HIB_W2;
			ST_DOZE_W1: state_next = ST_DOZE_W2;
			// R18: 40us reset unless retained
			// R10: retention skips the reset
			ST_HIB_W2, ST_DOZE_W2: begin
				// Count runs from zero, so stop one short for exact length
				if (retain_reg || wait_reg == CNT_W'(MCU_RESET_CYC - 1)) begin
					wait_next = '0;
					state_next = (state_reg == ST_HIB_W2) ? ST_HIB_W3
						: ST_DOZE_W3;
				end else begin
					wait_next = wait_reg + CNT_W'(1);
				end
			end
			// R19: sync handshake then MAC clock, back to run
			ST_HIB_W3, ST_DOZE_W3: begin
				if (!sync_reg && wait_reg == '0) begin
					sync_next = 1'b1;
					wait_next = CNT_W'(1);
				end else if (sync_clr) begin
					wait_next = '0;
					// R9: back to idle/run
					state_next = ST_RUN;
				end
			end
			default: state_next = ST_RUN;
		endcase
	end

	// Power controls decoded from state
	always_comb begin
		pwr = '0;
		unique case (state_reg)
			ST_RUN, ST_PRE_HIB, ST_PRE_DOZE: begin
				pwr = '1;
				pwr.mcu_reset = 1'b0;
			end
			ST_HIBERNATE: begin
				pwr.vref_on = wait_reg != '0;
				pwr.osc_reg_on = wait_reg != '0;
				pwr.ref_osc_on = wait_reg != '0;
			end
			// R20: reference keeps running in doze
			ST_DOZE: begin
				pwr.ref_osc_on = 1'b1;
				pwr.osc_reg_on = 1'b1;
				pwr.vref_on = wait_reg != '0;
			end
			ST_HIB_W1, ST_DOZE_W1: begin
				pwr.vref_on = 1'b1;
				pwr.ref_osc_on = 1'b1;
				pwr.osc_reg_on = 1'b1;
				pwr.dig_reg_on = 1'b1;
				pwr.pad_ring_on = 1'b1;
				pwr.mcu_pwr_on = 1'b1;
				pwr.fsm_on_ref = 1'b1;
			end
			ST_HIB_W2, ST_DOZE_W2, ST_HIB_W3, ST_DOZE_W3: begin
				pwr = '1;
				pwr.mac_clk_on = 1'b0;
				pwr.mcu_clk_on = state_reg == ST_HIB_W3 ||
					state_reg == ST_DOZE_W3;
				pwr.mcu_reset = (state_reg == ST_HIB_W2 ||
					state_reg == ST_DOZE_W2) && !retain_reg;
			end
			default: pwr = '0;
		endcase
	end

	// All registers
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			state_reg <= ST_RUN;
			wait_reg <= '0;
			xtal_present_reg <= 1'b0;
			ring_en_reg <= RING_EN_RESET;
			xtal_en_reg <= 1'b0;
			// R2: gain resets to maximum
			gain_reg <= XTAL_GAIN_RESET;
			hib_req_reg <= 1'b0;
			doze_req_reg <= 1'b0;
			retain_reg <= 1'b0;
			sync_reg <= 1'b0;
			hib_flag_reg <= 1'b0;
			doze_flag_reg <= 1'b0;
			tmr_en_reg <= 1'b0;
			rtc_en_reg <= 1'b0;
			tmo_reg <= 32'h0000_0000;
			wcnt_reg <= 32'h0000_0000;
			rtc_reg <= 32'h0000_0000;
			bvalid_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_bad_reg <= 1'b0;
			bresp_bad_reg <= 1'b0;
			PWR_CTRL <= '0;
		end else begin
			state_reg <= state_next;
			wait_reg <= wait_next;
			xtal_present_reg <= xtal_present_next;
			ring_en_reg <= ring_en_next;
			xtal_en_reg <= xtal_en_next;
			gain_reg <= gain_next;
			hib_req_reg <= hib_req_next;
			doze_req_reg <= doze_req_next;
			retain_reg <= retain_next;
			sync_reg <= sync_next;
			hib_flag_reg <= hib_flag_next;
			doze_flag_reg <= doze_flag_next;
			tmr_en_reg <= tmr_en_next;
			rtc_en_reg <= rtc_en_next;
			tmo_reg <= tmo_next;
			wcnt_reg <= wcnt_next;
			rtc_reg <= rtc_next;
			bvalid_reg <= bvalid_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_bad_reg <= rresp_bad_next;
			bresp_bad_reg <= bresp_bad_next;
			PWR_CTRL <= pwr;
		end
	end

	// Outputs
	assign S_AXI_BVALID = bvalid_reg;
	assign S_AXI_BRESP = bresp_bad_reg ? 2'h2 : 2'h0;
	assign S_AXI_RVALID = rvalid_reg;
	assign S_AXI_RDATA = rdata_reg;
	assign S_AXI_RRESP = rresp_bad_reg ? 2'h2 : 2'h0;
	assign XTAL_ENABLE = xtal_en_reg;
	assign XTAL_GAIN = gain_reg;
	assign RING_ENABLE = ring_en_reg;
	assign LP_CLK_IS_XTAL = xtal_present_reg;
	assign RTC_TICK = lp_tick;
	assign WAKE_TIMER_TICK = (state_reg == ST_DOZE) ? ref_div_tick : lp_tick;
endmodule // lpms_sequencer

// file: bench/lpms_asserts.sv
// Port-level checks for the power mode sequencer
module lpms_asserts (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// Write handshake
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// Oscillators and power controls
	input wire logic RING_TICK,
	input wire logic XTAL_TICK,
	input wire lpms_pkg::lpms_pwr_s PWR_CTRL,
	input wire logic XTAL_ENABLE,
	input wire logic [1:0] XTAL_GAIN,
	input wire logic LP_CLK_IS_XTAL,
	input wire logic RTC_TICK
);
	timeunit 1ns;
	timeprecision 1ns;
	import lpms_pkg::*;
	default clocking dc @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);
	logic [15:0] rst_cnt_reg, rst_cnt_next;
	logic [CNT_W-1:0] ref_cnt_reg, ref_cnt_next;
	// Reset pulse length and warm-up time, counted in cycles
	always_comb begin
		rst_cnt_next = PWR_CTRL.mcu_reset ? rst_cnt_reg + 16'h1 : 16'h0;
		ref_cnt_next = ref_cnt_reg;
		if (!PWR_CTRL.vref_on)
			ref_cnt_next = 17'h0;
		else if (!PWR_CTRL.dig_reg_on)
			ref_cnt_next = ref_cnt_reg + 17'h1;
	end
	// Counter registers
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			rst_cnt_reg <= 16'h0;
			ref_cnt_reg <= 17'h0;
		end else begin
			rst_cnt_reg <= rst_cnt_next;
			ref_cnt_reg <= ref_cnt_next;
		end
	end
	AST_B_ONE: assert property (S_AXI_AWVALID && S_AXI_AWREADY
		&& S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID)
		else $error("write not answered next cycle");
	AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY
		|=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response not held");
	AST_XTAL_STICKY: assert property (XTAL_ENABLE |=> XTAL_ENABLE)
		else $error("crystal switched off");
	AST_RTC_SRC: assert property (RTC_TICK == (LP_CLK_IS_XTAL ?
		XTAL_TICK : RING_TICK)) else $error("rtc tick wrong source");
	AST_GAIN_RST: assert property ($rose(RST_N) |->
		XTAL_GAIN == XTAL_GAIN_RESET && !XTAL_ENABLE)
		else $error("crystal control reset value wrong");
	AST_RST_LEN: assert property ($fell(PWR_CTRL.mcu_reset) |->
		rst_cnt_reg == MCU_RESET_CYC) else $error("reset pulse length");
	AST_MAC_LAST: assert property ($rose(PWR_CTRL.mac_clk_on) |->
		PWR_CTRL.mcu_clk_on && !PWR_CTRL.mcu_reset)
		else $error("mac clock before processor ready");
	AST_REF_WAIT: assert property ($rose(PWR_CTRL.dig_reg_on)
		&& $past(PWR_CTRL.vref_on) |-> ref_cnt_reg >= REF_WAIT_CYC)
		else $error("regulator on before warm-up ends");
endmodule // lpms_asserts

bind lpms_sequencer lpms_asserts lpms_asserts_inst (.SYS_CLK, .RST_N,
	.S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
	.S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .RING_TICK, .XTAL_TICK,
	.PWR_CTRL, .XTAL_ENABLE, .XTAL_GAIN, .LP_CLK_IS_XTAL, .RTC_TICK);

// file: bench/lpms_far_side.sv
// Behavioural slow oscillators seen by the sequencer
module lpms_far_side #(
	parameter int RING_DIV = 40,
	parameter int XTAL_DIV = 40,
	parameter int XTAL_START = 200
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Enables and ticks
	input wire logic ring_en,
	input wire logic xtal_en,
	output logic ring_tick,
	output logic xtal_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	int rc, xc, up;
	// crystal ticks only once enabled and started; stops on reset
	// Start-up is far shorter than a real crystal to keep the run short
	always @(posedge clk) begin
		rc <= (rc + 1) % RING_DIV;
		xc <= (xc + 1) % XTAL_DIV;
		up <= (rst_n && xtal_en) ? up + 1 : 0;
		ring_tick <= ring_en && rc == 0;
		xtal_tick <= up > XTAL_START && xc == 0;
	end
endmodule // lpms_far_side

// file: bench/tb.sv
// Self-checking bench for the power mode sequencer
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lpms_pkg::*;
	logic clk, rst_n, aw_v, w_v, b_rdy, ar_v, r_rdy, ext_wake;
	logic awready, wready, bvalid, arready, rvalid, ring_tick, xtal_tick;
	logic xtal_en, ring_en, lp_xtal, rtc_tick, wt_tick;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, v;
	logic [1:0] bresp, rresp, gain;
	lpms_pwr_s pwr;
	int n_errors, check_count, n;

	// 100 MHz clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	lpms_sequencer lpms_sequencer_inst (.SYS_CLK(clk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(b_rdy), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(ar_v),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(r_rdy), .RING_TICK(ring_tick),
		.XTAL_TICK(xtal_tick), .EXT_WAKE(ext_wake), .PWR_CTRL(pwr),
		.XTAL_ENABLE(xtal_en), .XTAL_GAIN(gain), .RING_ENABLE(ring_en),
		.LP_CLK_IS_XTAL(lp_xtal), .RTC_TICK(rtc_tick),
		.WAKE_TIMER_TICK(wt_tick));
	lpms_far_side lpms_far_side_inst (.clk(clk), .rst_n(rst_n),
		.ring_en(ring_en), .xtal_en(xtal_en), .ring_tick(ring_tick),
		.xtal_tick(xtal_tick));

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One write; ready is raised late so the response must wait
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er = 2'h0);
		awaddr <= a;
		wdata <= d;
		aw_v <= 1'h1;
		w_v <= 1'h1;
		do @(negedge clk); while (!(awready && wready));
		@(posedge clk);
		aw_v <= 1'h0;
		w_v <= 1'h0;
		@(posedge clk);
		b_rdy <= 1'h1;
		do @(negedge clk); while (!bvalid);
		chk("bresp", 32'(er), 32'(bresp));
		@(posedge clk);
		b_rdy <= 1'h0;
	endtask

	// One read into rd
	task automatic rdr(input logic [7:0] a, input logic [1:0] er = 2'h0);
		araddr <= a;
		ar_v <= 1'h1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		ar_v <= 1'h0;
		@(posedge clk);
		r_rdy <= 1'h1;
		do @(negedge clk); while (!rvalid);
		rd = rdata;
		chk("rresp", 32'(er), 32'(rresp));
		@(posedge clk);
		r_rdy <= 1'h0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rdr(a);
		chk("rdata", e, rd);
	endtask

	// Bounded poll of one status bit
	task automatic poll(input int b);
		n = 0;
		do begin
			rdr(OFS_STATUS);
			n++;
		end while (rd[b] !== 1'h1 && n < 400);
		chk("status bit", 32'h1, 32'(rd[b]));
	endtask

	task automatic test_done();
		if (n_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Watchdog well past the expected run of about 76000 cycles
	initial begin
		#1000000;
		n_errors++;
		test_done();
	end

	initial begin
		{rst_n, aw_v, w_v, b_rdy, ar_v, r_rdy, ext_wake} = 7'h0;
		awaddr = 8'h0;
		araddr = 8'h0;
		wdata = 32'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		rdc(OFS_XTAL_CTRL, 32'h30);
		rdc(OFS_SYS_CTRL, 32'h1);
		rdr(8'h40, 2'h2);
		wr(8'h44, 32'h0, 2'h2);
		// Ring off, crystal on, wait, then select it
		wr(OFS_SYS_CTRL, 32'h0);
		chk("ring en", 32'h0, 32'(ring_en));
		wr(OFS_XTAL_CTRL, 32'h31);
		chk("xtal_en", 32'h1, 32'(xtal_en));
		wr(OFS_XTAL_CTRL, 32'h30);
		rdc(OFS_XTAL_CTRL, 32'h31);
		repeat (300) @(posedge clk);
		wr(OFS_SYS_CTRL, 32'h20);
		chk("lp clk", 32'h1, 32'(lp_xtal));
		do @(negedge clk); while (!xtal_tick);
		chk("rtc tick", 32'h1, 32'(rtc_tick));
		@(posedge clk);
		rdr(OFS_RTC_COUNT);
		v = rd;
		repeat (100) @(posedge clk);
		rdr(OFS_RTC_COUNT);
		chk("rtc moved", 32'h1, 32'(rd != v));
		// Both bits set: hibernate takes precedence
		wr(OFS_SLEEP_CTRL, 32'h3);
		rdc(OFS_PWR_STATE, {28'h0, ST_PRE_HIB});
		poll(ST_SYNC_BIT);
		wr(OFS_STATUS, 32'h1);
		rdc(OFS_PWR_STATE, {28'h0, ST_HIBERNATE});
		chk("hib pwr", 32'h0, 32'({pwr.mcu_clk_on, pwr.ref_osc_on}));
		ext_wake <= 1'h1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!pwr.mcu_reset && n < 80000);
		chk("warm-up", 32'h1,
			32'(n >= REF_WAIT_CYC && n < REF_WAIT_CYC + 16));
		chk("step1", 32'h7,
			32'({pwr.pad_ring_on, pwr.dig_reg_on, pwr.fsm_on_ref}));
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (pwr.mcu_reset && n < 9000);
		chk("reset len", MCU_RESET_CYC, n);
		@(posedge clk);
		ext_wake <= 1'h0;
		poll(ST_SYNC_BIT);
		rdc(OFS_STATUS, 32'h3);
		chk("mac off", 32'h0, 32'(pwr.mac_clk_on));
		wr(OFS_STATUS, 32'h7);
		rdc(OFS_PWR_STATE, {28'h0, ST_RUN});
		chk("mac on", 32'h1, 32'(pwr.mac_clk_on));
		rdc(OFS_STATUS, 32'h0);
		// Doze with retention, woken by the timer
		wr(OFS_WAKE_TIMEOUT, 32'h8);
		wr(OFS_WAKE_CTRL, 32'h1);
		wr(OFS_SLEEP_CTRL, 32'h6);
		poll(ST_SYNC_BIT);
		wr(OFS_STATUS, 32'h1);
		rdc(OFS_PWR_STATE, {28'h0, ST_DOZE});
		chk("doze pwr", 32'h2, 32'({pwr.ref_osc_on, pwr.mcu_clk_on}));
		do @(negedge clk); while (!wt_tick);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!wt_tick && n < 1000);
		chk("tick gap", REF_DIV, n);
		@(posedge clk);
		poll(ST_DOZE_WAKE_BIT);
		chk("hib flag", 32'h0, 32'(rd[ST_HIB_WAKE_BIT]));
		// A reset mid-run is the only way to stop the crystal
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		@(negedge clk);
		chk("xtal off", 32'h0, 32'(xtal_en));
		chk("gain", 32'h3, 32'(gain));
		chk("ring on", 32'h1, 32'(ring_en));
		// The machine must come back up in run after the second reset
		@(posedge clk);
		rdc(OFS_PWR_STATE, {28'h0, ST_RUN});
		test_done();
	end
endmodule // tb
